/* File: rtl/aunaf_pkg.sv */
// Constants, register map and types for the ninth-bit serial port
package aunaf_pkg;
  // Register indices; the bus byte address is four times the index
  localparam logic [7:0] IDX_CTRL0 = 8'h98;
  localparam logic [7:0] IDX_CTRL1 = 8'hC0;
  localparam logic [7:0] IDX_BUF0 = 8'h99;
  localparam logic [7:0] IDX_BUF1 = 8'hC1;
  localparam logic [7:0] IDX_ADDR0 = 8'hA9;
  localparam logic [7:0] IDX_ADDR1 = 8'hAA;
  localparam logic [7:0] IDX_MASK0 = 8'hB9;
  localparam logic [7:0] IDX_MASK1 = 8'hBA;
  localparam logic [7:0] IDX_POWER = 8'h87;
  localparam logic [7:0] IDX_BAUD = 8'h8D;
  // serial_control fields
  localparam int CTRL_MODE_LOW = 7;
  localparam int CTRL_MODE_HIGH = 6;
  localparam int CTRL_FILTER = 5;
  localparam int CTRL_RX_PERMIT = 4;
  localparam int CTRL_TX_NINTH = 3;
  localparam int CTRL_RX_NINTH = 2;
  localparam int CTRL_TX_DONE = 1;
  localparam int CTRL_RX_DONE = 0;
  // power_control fields
  localparam int POWER_DOUBLE = 7;
  localparam int POWER_FAULT_VIEW = 6;
  // Reset values
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] BAUD_RESET = 8'h0C;
  // Oversampling and fixed-rate dividers
  localparam logic [3:0] SAMPLE_FIRST = 4'h7;
  localparam logic [3:0] SAMPLE_MID = 4'h8;
  localparam logic [3:0] SAMPLE_LAST = 4'h9;
  localparam logic [3:0] CNT_LAST = 4'hF;
  localparam logic [2:0] FIXED_DIV_FAST = 3'h2;
  localparam logic [2:0] FIXED_DIV_SLOW = 3'h4;
  // Bit positions within a frame, start bit is 0
  localparam logic [3:0] BIT_START = 4'h0;
  localparam logic [3:0] BIT_NINE = 4'h9;
  localparam logic [3:0] BIT_STOP11 = 4'hA;
  localparam logic [3:0] TX_BITS10 = 4'h9;
  localparam logic [3:0] TX_BITS11 = 4'hA;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_CTRL = 3'b001,
    SEL_BUF = 3'b010,
    SEL_ADDR = 3'b011,
    SEL_MASK = 3'b100,
    SEL_POWER = 3'b101,
    SEL_BAUD = 3'b110
  } aunaf_sel_type;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_SHIFT = 2'b01
  } aunaf_rx_state_type;
endpackage

/* File: rtl/aunaf_baud_tick.sv */
// Oversample tick generator: fixed clock divide or programmable period
`timescale 1ns/1ps
`default_nettype none
module aunaf_baud_tick
  import aunaf_pkg::*;
#(
  parameter int DIV_W = 8
)
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic fixed_rate_in,
  input wire logic double_in,
  input wire logic [DIV_W-1:0] divisor_in,
  output logic tick_out
);
  generate
    if (DIV_W < 3)
    begin : g_check
      $error("DIV_W must be at least 3");
    end
  endgenerate

  typedef struct packed {
    logic [DIV_W-1:0] count;
    logic tick;
  } aunaf_tick_state_type;

  aunaf_tick_state_type state_ff;
  aunaf_tick_state_type nxt_state;
  logic [DIV_W-1:0] last;

  always_comb
  begin
    // Fixed mode divides the clock by 2 or 4; else the programmed period
    if (fixed_rate_in)
      last = DIV_W'(double_in ? FIXED_DIV_FAST - 3'h1 : FIXED_DIV_SLOW - 3'h1);
    else
      last = divisor_in;
    nxt_state = state_ff;
    nxt_state.tick = (state_ff.count >= last);
    nxt_state.count = (state_ff.count >= last) ? '0 : state_ff.count + DIV_W'(1);
  end

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      state_ff <= '0;
    else
      state_ff <= nxt_state;
  end

  assign tick_out = state_ff.tick;
endmodule
`default_nettype wire

/* File: rtl/aunaf_serial_port.sv */
// Asynchronous 10/11-bit serial port with station address filter, AXI4-Lite registers
// Overview of operation
// - 10-bit frame: low start, eight data bits LSB first, high stop.
// - 10-bit: mid-stop accept if done clear and stop high when filtering.
// - Rejected frame leaves buffer, ninth-bit flag and receive-done untouched.
// - After mid-stop the receiver looks for a new falling edge.
// - Each bit sampled at ticks 7, 8, 9; two of three decide.
// - A voted-high start bit abandons the frame.
// - 11-bit frame: start, eight data, programmable ninth bit, stop.
// - Transmit ninth bit latched from its control bit at buffer write.
// - Transmit starts at next counter rollover: start, data, ninth in 11-bit frames, stop.
// - Transmit-done set when the stop bit is driven.
// - Receive only with receive-permit set; falling edge starts frame.
// - 11-bit: mid-ninth accept if done clear and ninth high when filtering.
// - Fixed-rate 11-bit mode ticks from clock divided by 2 or 4.
// - Timer 11-bit mode differs only in its programmable tick source.
// - Frame-fault set on bad stop; only software clears it.
// - Fault-view select steers control bit 7 between fault flag and mode.
// - Filtered ninth-bit frame is an address; done only on match.
// - Address compare ignores bits where the station mask is zero.
// - Broadcast address, address OR mask, also matches.
// - Each port has its own station address and mask registers.
// - Mask resets to zero so every address matches.
`timescale 1ns/1ps
`default_nettype none
module aunaf_serial_port
  import aunaf_pkg::*;
#(
  parameter int PORT_INDEX = 0,
  parameter int ADDR_W = 12,
  parameter int DIV_W = 8
)
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic serial_rx_in,
  output logic serial_tx_out
);
  generate
    if (PORT_INDEX < 0 || PORT_INDEX > 1 || ADDR_W < 10 || DIV_W > 8)
    begin : g_check
      $error("PORT_INDEX must be 0 or 1, ADDR_W at least 10, DIV_W at most 8");
    end
  endgenerate

  // Per-port register indices
  localparam logic [7:0] MY_CTRL = (PORT_INDEX == 0) ? IDX_CTRL0 : IDX_CTRL1;
  localparam logic [7:0] MY_BUF = (PORT_INDEX == 0) ? IDX_BUF0 : IDX_BUF1;
  localparam logic [7:0] MY_ADDR = (PORT_INDEX == 0) ? IDX_ADDR0 : IDX_ADDR1;
  localparam logic [7:0] MY_MASK = (PORT_INDEX == 0) ? IDX_MASK0 : IDX_MASK1;

  typedef struct packed {
    // serial_control and its shadow fault flag, then the other port registers
    logic mode_low;
    logic mode_high;
    logic addr_filter_on;
    logic rx_permit;
    logic tx_ninth_bit;
    logic rx_ninth_bit;
    logic tx_done_flag;
    logic rx_done_flag;
    logic frame_fault_flag;
    logic fault_view_select;
    logic baud_double;
    logic [7:0] station_address;
    logic [7:0] station_mask;
    logic [7:0] rx_buffer;
    logic [7:0] baud_period;
    // Receiver
    aunaf_rx_state_type rx_state;
    logic rx_prev;
    logic [3:0] rx_bit;
    logic [3:0] rx_cnt;
    logic rx_s7;
    logic rx_s8;
    logic [7:0] rx_shift;
    // Transmitter
    logic [3:0] tx_cnt;
    logic tx_pending;
    logic tx_pending_ninth;
    logic [7:0] tx_pending_data;
    logic tx_active;
    logic [9:0] tx_shift;
    logic [3:0] tx_left;
    logic tx_line;
    // Bus
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } aunaf_state_type;

  aunaf_state_type state_ff;
  aunaf_state_type nxt_state;
  logic tick;
  logic mode_active;
  logic frame11;
  logic vote;
  logic [3:0] cnt_inc;
  logic [7:0] wbyte;
  logic [7:0] ctrl_view;
  aunaf_sel_type wsel;
  aunaf_sel_type rsel;

  function automatic aunaf_sel_type decode_sel(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-3:0] idx;
    idx = addr[ADDR_W-1:2];
    if (idx == (ADDR_W-2)'(MY_CTRL))
      return SEL_CTRL;
    else if (idx == (ADDR_W-2)'(MY_BUF))
      return SEL_BUF;
    else if (idx == (ADDR_W-2)'(MY_ADDR))
      return SEL_ADDR;
    else if (idx == (ADDR_W-2)'(MY_MASK))
      return SEL_MASK;
    else if (idx == (ADDR_W-2)'(IDX_POWER))
      return SEL_POWER;
    else if (idx == (ADDR_W-2)'(IDX_BAUD))
      return SEL_BAUD;
    else
      return SEL_NONE;
  endfunction

  // Individual address or broadcast address match
  function automatic logic addr_match(input logic [7:0] rx, input logic [7:0] own,
                                      input logic [7:0] mask);
    logic [7:0] bcast;
    bcast = own | mask;
    return (((rx ^ own) & mask) == 8'h00) ||
           (((rx ^ bcast) & bcast) == 8'h00);
  endfunction

  // Fixed-rate mode only for mode 2; timer-driven modes use the period register
  aunaf_baud_tick #(
    .DIV_W(DIV_W)
  ) aunaf_baud_tick_inst (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .fixed_rate_in(state_ff.mode_high && !state_ff.mode_low),
    .double_in(state_ff.baud_double),
    .divisor_in(state_ff.baud_period[DIV_W-1:0]),
    .tick_out(tick)
  );

  assign mode_active = state_ff.mode_low || state_ff.mode_high;
  assign frame11 = state_ff.mode_high;
  assign cnt_inc = state_ff.rx_cnt + 4'h1;
  assign vote = (state_ff.rx_s7 & state_ff.rx_s8) | (state_ff.rx_s7 & serial_rx_in) |
                (state_ff.rx_s8 & serial_rx_in);
  assign wsel = decode_sel(state_ff.aw_addr);
  assign rsel = decode_sel(s_axi_araddr_in);
  assign wbyte = state_ff.w_data;
  assign ctrl_view = {state_ff.fault_view_select ? state_ff.frame_fault_flag
                                                 : state_ff.mode_low,
                      state_ff.mode_high, state_ff.addr_filter_on, state_ff.rx_permit,
                      state_ff.tx_ninth_bit, state_ff.rx_ninth_bit, state_ff.tx_done_flag,
                      state_ff.rx_done_flag};

  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.rx_prev = serial_rx_in;

    // Register writes come first so hardware events below win over clears
    if (state_ff.aw_held && state_ff.w_held && !state_ff.bvalid)
    begin
      nxt_state.aw_held = 1'b0;
      nxt_state.w_held = 1'b0;
      nxt_state.bvalid = 1'b1;
      nxt_state.bresp = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      if (state_ff.w_lane0)
      begin
        case (wsel)
          SEL_CTRL:
          begin
            if (state_ff.fault_view_select)
              nxt_state.frame_fault_flag = wbyte[CTRL_MODE_LOW];
            else
              nxt_state.mode_low = wbyte[CTRL_MODE_LOW];
            nxt_state.mode_high = wbyte[CTRL_MODE_HIGH];
            nxt_state.addr_filter_on = wbyte[CTRL_FILTER];
            nxt_state.rx_permit = wbyte[CTRL_RX_PERMIT];
            nxt_state.tx_ninth_bit = wbyte[CTRL_TX_NINTH];
            nxt_state.rx_ninth_bit = wbyte[CTRL_RX_NINTH];
            nxt_state.tx_done_flag = wbyte[CTRL_TX_DONE];
            nxt_state.rx_done_flag = wbyte[CTRL_RX_DONE];
          end
          SEL_BUF:
          begin
            nxt_state.tx_pending = 1'b1;
            nxt_state.tx_pending_data = wbyte;
            nxt_state.tx_pending_ninth = state_ff.tx_ninth_bit;
          end
          SEL_ADDR: nxt_state.station_address = wbyte;
          SEL_MASK: nxt_state.station_mask = wbyte;
          SEL_POWER:
          begin
            nxt_state.baud_double = wbyte[POWER_DOUBLE];
            nxt_state.fault_view_select = wbyte[POWER_FAULT_VIEW];
          end
          SEL_BAUD: nxt_state.baud_period = wbyte;
          default: nxt_state.bresp = RESP_SLVERR;
        endcase
      end
    end
    if (s_axi_awvalid_in && s_axi_awready_out)
    begin
      nxt_state.aw_held = 1'b1;
      nxt_state.aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_axi_wready_out)
    begin
      nxt_state.w_held = 1'b1;
      nxt_state.w_data = s_axi_wdata_in[7:0];
      nxt_state.w_lane0 = s_axi_wstrb_in[0];
    end
    if (state_ff.bvalid && s_axi_bready_in)
      nxt_state.bvalid = 1'b0;

    // Register reads
    if (state_ff.rvalid && s_axi_rready_in)
      nxt_state.rvalid = 1'b0;
    if (s_axi_arvalid_in && s_axi_arready_out)
    begin
      nxt_state.rvalid = 1'b1;
      nxt_state.rresp = (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      case (rsel)
        SEL_CTRL: nxt_state.rdata = {24'h000000, ctrl_view};
        SEL_BUF: nxt_state.rdata = {24'h000000, state_ff.rx_buffer};
        SEL_ADDR: nxt_state.rdata = {24'h000000, state_ff.station_address};
        SEL_MASK: nxt_state.rdata = {24'h000000, state_ff.station_mask};
        SEL_POWER: nxt_state.rdata = {24'h000000, state_ff.baud_double,
                                      state_ff.fault_view_select, 6'h00};
        SEL_BAUD: nxt_state.rdata = {24'h000000, state_ff.baud_period};
        default: nxt_state.rdata = 32'h00000000;
      endcase
    end

    // Receiver
    case (state_ff.rx_state)
      RX_IDLE:
      begin
        if (mode_active && state_ff.rx_permit && state_ff.rx_prev && !serial_rx_in)
        begin
          nxt_state.rx_state = RX_SHIFT;
          nxt_state.rx_bit = BIT_START;
          nxt_state.rx_cnt = 4'h0;
        end
      end
      RX_SHIFT:
      begin
        if (!mode_active || !state_ff.rx_permit)
          nxt_state.rx_state = RX_IDLE;
        else if (tick)
        begin
          nxt_state.rx_cnt = cnt_inc;
          if (cnt_inc == SAMPLE_FIRST)
            nxt_state.rx_s7 = serial_rx_in;
          if (cnt_inc == SAMPLE_MID)
            nxt_state.rx_s8 = serial_rx_in;
          if (cnt_inc == 4'h0)
            nxt_state.rx_bit = state_ff.rx_bit + 4'h1;
          if (cnt_inc == SAMPLE_LAST)
          begin
            if (state_ff.rx_bit == BIT_START)
            begin
              if (vote)
                nxt_state.rx_state = RX_IDLE;
            end
            else if (state_ff.rx_bit < BIT_NINE)
              nxt_state.rx_shift = {vote, state_ff.rx_shift[7:1]};
            else if (state_ff.rx_bit == BIT_NINE)
            begin
              // Bit nine is the stop bit in 10-bit frames, the ninth bit otherwise
              if (!state_ff.rx_done_flag &&
                  (!state_ff.addr_filter_on || (vote &&
                   (!frame11 || addr_match(state_ff.rx_shift, state_ff.station_address,
                                           state_ff.station_mask)))))
              begin
                nxt_state.rx_buffer = state_ff.rx_shift;
                nxt_state.rx_ninth_bit = vote;
                nxt_state.rx_done_flag = 1'b1;
              end
              if (!frame11)
              begin
                if (!vote)
                  nxt_state.frame_fault_flag = 1'b1;
                nxt_state.rx_state = RX_IDLE;
              end
            end
            else
            begin
              if (!vote)
                nxt_state.frame_fault_flag = 1'b1;
              nxt_state.rx_state = RX_IDLE;
            end
          end
        end
      end
      default: nxt_state.rx_state = RX_IDLE;
    endcase

    // Transmitter: bits change only at rollovers of the free tick counter
    if (tick)
    begin
      nxt_state.tx_cnt = state_ff.tx_cnt + 4'h1;
      if (state_ff.tx_cnt == CNT_LAST)
      begin
        if (state_ff.tx_active)
        begin
          if (state_ff.tx_left == 4'h0)
            nxt_state.tx_active = 1'b0;
          else
          begin
            nxt_state.tx_line = state_ff.tx_shift[0];
            nxt_state.tx_shift = {1'b1, state_ff.tx_shift[9:1]};
            nxt_state.tx_left = state_ff.tx_left - 4'h1;
            if (state_ff.tx_left == 4'h1)
              nxt_state.tx_done_flag = 1'b1;
          end
        end
        else if (state_ff.tx_pending && mode_active)
        begin
          nxt_state.tx_pending = 1'b0;
          nxt_state.tx_active = 1'b1;
          nxt_state.tx_line = 1'b0;
          nxt_state.tx_shift = frame11 ? {1'b1, state_ff.tx_pending_ninth,
                                          state_ff.tx_pending_data}
                                       : {2'b11, state_ff.tx_pending_data};
          nxt_state.tx_left = frame11 ? TX_BITS11 : TX_BITS10;
        end
      end
    end
  end

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      state_ff <= '0;
      state_ff.rx_state <= RX_IDLE;
      state_ff.station_address <= ADDR_RESET;
      state_ff.station_mask <= MASK_RESET;
      state_ff.baud_period <= BAUD_RESET;
      state_ff.tx_line <= 1'b1;
      state_ff.rx_prev <= 1'b1;
      state_ff.tx_shift <= 10'h3FF;
    end
    else
      state_ff <= nxt_state;
  end

  // One write and one read outstanding at a time
  assign s_axi_awready_out = !state_ff.aw_held && !state_ff.bvalid;
  assign s_axi_wready_out = !state_ff.w_held && !state_ff.bvalid;
  assign s_axi_bvalid_out = state_ff.bvalid;
  assign s_axi_bresp_out = state_ff.bresp;
  assign s_axi_arready_out = !state_ff.rvalid;
  assign s_axi_rvalid_out = state_ff.rvalid;
  assign s_axi_rdata_out = state_ff.rdata;
  assign s_axi_rresp_out = state_ff.rresp;
  assign serial_tx_out = state_ff.tx_line;
endmodule
`default_nettype wire

/* File: verification/aunaf_serial_port_checker.sv */
// Bus and serial line checks for the ninth-bit serial port
`timescale 1ns/1ps
`default_nettype none
module aunaf_serial_port_checker
  import aunaf_pkg::*;
#(
  parameter int PORT_INDEX = 0,
  parameter int ADDR_W = 12
)
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0] s_axi_rresp_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic serial_rx_in,
  input wire logic serial_tx_out
);
  localparam logic [7:0] BUF_IDX = PORT_INDEX == 0 ? IDX_BUF0 : IDX_BUF1;
  localparam logic [7:0] ALIEN_IDX = PORT_INDEX == 0 ? IDX_MASK1 : IDX_MASK0;
  logic wr_go;
  logic rd_go;
  assign wr_go = s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
  assign rd_go = s_axi_arvalid_in && s_axi_arready_out;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);
  // Buffer is only loaded with the line idle, so high tx means idle here
  chk_tx_start_late:
    assert property (wr_go && s_axi_wstrb_in[0] && serial_tx_out
      && s_axi_awaddr_in == ADDR_W'({BUF_IDX, 2'b00}) |-> ##[1:120] !serial_tx_out)
    else $error("transmit did not start");
  chk_start_hold:
    assert property ($fell(serial_tx_out) |=> !serial_tx_out [*7])
    else $error("start bit too short");
  chk_bit_hold:
    assert property ($changed(serial_tx_out) |=> $stable(serial_tx_out) [*7])
    else $error("tx bit too short");
  chk_frame_close:
    assert property ($fell(serial_tx_out) |-> ##[1:800] serial_tx_out)
    else $error("tx frame never closed");
  chk_alien_port:
    assert property (rd_go && s_axi_araddr_in == ADDR_W'({ALIEN_IDX, 2'b00})
      |=> s_axi_rvalid_out && s_axi_rresp_out == RESP_SLVERR)
    else $error("other port register answered");
  chk_read_answer:
    assert property (rd_go |=> s_axi_rvalid_out)
    else $error("read not answered");
  chk_write_answer:
    assert property (wr_go |-> ##[1:2] s_axi_bvalid_out)
    else $error("write not answered");
  chk_write_unmapped:
    assert property (wr_go && s_axi_awaddr_in == '0
      |-> ##[1:2] s_axi_bvalid_out && s_axi_bresp_out == RESP_SLVERR)
    else $error("unmapped write accepted");
  chk_rdata_upper:
    assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h0)
    else $error("read data upper bits set");
  cover property ($fell(serial_tx_out));
  cover property (rd_go);
  cover property (s_axi_bvalid_out && s_axi_bresp_out == RESP_SLVERR);
endmodule
`default_nettype wire

/* File: verification/aunaf_peer_model.sv */
// Remote serial peer: sends and captures 10/11-bit frames
`timescale 1ns/1ps
`default_nettype none
module aunaf_peer_model
(
  input wire logic clk_in,
  input wire logic serial_tx_in,
  output logic serial_rx_out
);
  int bit_clks = 48;
  logic frame11 = 1'b1;
  logic [10:0] got;
  int got_count = 0;
  initial serial_rx_out = 1'b1;
  // Short low pulse that must not pass for a start bit
  task automatic blip();
    @(posedge clk_in);
    serial_rx_out <= 1'b0;
    repeat (6) @(posedge clk_in);
    serial_rx_out <= 1'b1;
    repeat (bit_clks) @(posedge clk_in);
  endtask
  task automatic send(input logic [7:0] d, input logic ninth, input logic stop, input logic gl);
    logic [10:0] b;
    b = frame11 ? {stop, ninth, d, 1'b0} : {1'b1, stop, d, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      for (int c = 0; c < bit_clks; c++)
      begin
        @(posedge clk_in);
        // One tick wide spike mid bit; the vote must outweigh it
        serial_rx_out <= b[i] ^ (gl && i == 1 && c > bit_clks / 2 - 2 && c < bit_clks / 2 + 2);
      end
    end
    @(posedge clk_in);
    serial_rx_out <= 1'b1;
  endtask
  always
  begin
    @(negedge serial_tx_in);
    repeat (bit_clks / 2) @(posedge clk_in);
    got[0] = serial_tx_in;
    for (int i = 1; i < (frame11 ? 11 : 10); i++)
    begin
      repeat (bit_clks) @(posedge clk_in);
      got[i] = serial_tx_in;
    end
    got_count++;
  end
endmodule
`default_nettype wire

/* File: verification/async_uart_ninth_bit_address_filter_bench.sv */
// Self-checking bench for the ninth-bit serial port
`timescale 1ns/1ps
`default_nettype none
module async_uart_ninth_bit_address_filter_bench;
  import aunaf_pkg::*;
  localparam int ADDR_W = 12;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [ADDR_W-1:0] s_axi_awaddr_in = '0;
  logic s_axi_awvalid_in = 1'b0;
  logic s_axi_awready_out;
  logic [31:0] s_axi_wdata_in = '0;
  logic [3:0] s_axi_wstrb_in = 4'h0;
  logic s_axi_wvalid_in = 1'b0;
  logic s_axi_wready_out;
  logic [1:0] s_axi_bresp_out;
  logic s_axi_bvalid_out;
  logic s_axi_bready_in = 1'b0;
  logic [ADDR_W-1:0] s_axi_araddr_in = '0;
  logic s_axi_arvalid_in = 1'b0;
  logic s_axi_arready_out;
  logic [31:0] s_axi_rdata_out;
  logic [1:0] s_axi_rresp_out;
  logic s_axi_rvalid_out;
  logic s_axi_rready_in = 1'b0;
  wire logic serial_rx_in;
  logic serial_tx_out;
  int num_errors = 0;
  int checked = 0;
  logic [7:0] q;
  logic [1:0] rs;
  // {control, data, flags glitch-start/spike/stop/ninth, expected control, expected buffer}
  logic [39:0] rows [12] = '{40'hD03C06D13C, 40'hD15503D13C, 40'hD0960BD596, 40'hC07702C096,
    40'hF0F203F096, 40'hF01202F096, 40'hF0F103F5F1, 40'hF0FF03F5FF, 40'hB05A02B55A,
    40'hB03300B05A, 40'h708100F05A, 40'hD04202D142};
  always #20 clk_in = ~clk_in;
  aunaf_serial_port #(.ADDR_W(ADDR_W)) aunaf_serial_port_inst (.clk_in, .reset_in,
    .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in,
    .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
    .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out,
    .s_axi_rvalid_out, .s_axi_rready_in, .serial_rx_in, .serial_tx_out);
  aunaf_peer_model aunaf_peer_model_inst (.clk_in, .serial_tx_in(serial_tx_out),
    .serial_rx_out(serial_rx_in));
  task automatic compare(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Outputs are read at the falling edge, where they are settled for the next rising edge
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    logic ta;
    logic tw;
    logic tb;
    @(posedge clk_in);
    s_axi_awaddr_in <= ADDR_W'({idx, 2'b00});
    s_axi_araddr_in <= ADDR_W'({idx, 2'b00});
    s_axi_wdata_in <= {24'h0, d};
    s_axi_wstrb_in <= 4'h1;
    s_axi_awvalid_in <= wr;
    s_axi_wvalid_in <= wr;
    s_axi_bready_in <= wr;
    s_axi_arvalid_in <= !wr;
    s_axi_rready_in <= !wr;
    do
    begin
      @(negedge clk_in);
      ta = wr ? s_axi_awvalid_in && s_axi_awready_out : s_axi_arvalid_in && s_axi_arready_out;
      tw = s_axi_wvalid_in && s_axi_wready_out;
      tb = wr ? s_axi_bvalid_out : s_axi_rvalid_out;
      q = s_axi_rdata_out[7:0];
      rs = wr ? s_axi_bresp_out : s_axi_rresp_out;
      @(posedge clk_in);
      if (ta && wr) s_axi_awvalid_in <= 1'b0;
      if (ta && !wr) s_axi_arvalid_in <= 1'b0;
      if (tw) s_axi_wvalid_in <= 1'b0;
    end while (!tb);
    s_axi_bready_in <= 1'b0;
    s_axi_rready_in <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    compare({24'h0, q}, {24'h0, e});
  endtask
  task automatic results();
    $display("mismatches %0d comparisons %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (40000) @(posedge clk_in);
    num_errors++;
    results();
  end
  initial
  begin
    logic fx;
    logic [39:0] r;
    repeat (4) @(posedge clk_in);
    reset_in <= 1'b0;
    rd_chk(IDX_MASK0, MASK_RESET);
    rd_chk(IDX_CTRL0, 8'h00);
    rd_chk(IDX_BAUD, BAUD_RESET);
    bus(1'b0, IDX_MASK1, 8'h00);
    compare({30'h0, rs}, {30'h0, RESP_SLVERR});
    bus(1'b1, 8'h00, 8'h5A);
    compare({30'h0, rs}, {30'h0, RESP_SLVERR});
    bus(1'b1, IDX_BAUD, 8'h02);
    bus(1'b1, IDX_ADDR0, 8'hF0);
    bus(1'b1, IDX_MASK0, 8'hFA);
    rd_chk(IDX_MASK0, 8'hFA);
    bus(1'b1, IDX_CTRL0, 8'hC8);
    bus(1'b1, IDX_BUF0, 8'hA5);
    bus(1'b1, IDX_CTRL0, 8'hC0);
    for (int n = 0; n < 2000 && aunaf_peer_model_inst.got_count == 0; n++) @(posedge clk_in);
    compare({21'h0, aunaf_peer_model_inst.got}, {21'h0, 11'h74A});
    rd_chk(IDX_CTRL0, 8'hC2);
    for (int i = 0; i < 12; i++)
    begin
      r = rows[i];
      fx = r[39:38] == 2'b01;
      // Fault view off first, so control bit 7 lands on the mode bit
      bus(1'b1, IDX_POWER, 8'h00);
      bus(1'b1, IDX_CTRL0, r[39:32]);
      if (fx) bus(1'b1, IDX_POWER, 8'hC0);
      aunaf_peer_model_inst.bit_clks = fx ? 32 : 48;
      aunaf_peer_model_inst.frame11 = r[38];
      if (r[19]) aunaf_peer_model_inst.blip();
      aunaf_peer_model_inst.send(r[31:24], r[16], r[17], r[18]);
      rd_chk(IDX_CTRL0, r[15:8]);
      rd_chk(IDX_BUF0, r[7:0]);
    end
    bus(1'b1, IDX_POWER, 8'hC0);
    rd_chk(IDX_CTRL0, 8'hD1);
    bus(1'b1, IDX_CTRL0, 8'h50);
    rd_chk(IDX_CTRL0, 8'h50);
    bus(1'b1, IDX_POWER, 8'h80);
    rd_chk(IDX_CTRL0, 8'hD0);
    results();
  end
endmodule
bind aunaf_serial_port aunaf_serial_port_checker #(.PORT_INDEX(PORT_INDEX), .ADDR_W(ADDR_W))
  aunaf_serial_port_checker_inst (.clk_in, .reset_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
  .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
  .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in,
  .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in,
  .serial_rx_in, .serial_tx_out);
`default_nettype wire
